//--- common/rst_strap_params.svh
// Contract
// RULE_01: Self-configuration starts only when the power-on reset input is seen to rise.
// RULE_02: While the power-on reset input is low every output stays inactive.
// RULE_03: The reset source releases power-on reset only once supplies and clocks are stable.
// RULE_04: Every test strap pin floats with only its weak pulldown while power-on reset is low.
// RULE_05: About 1.5 us after power-on reset rises the strap pins are sampled as test mode.
// RULE_06: Once sampled, the strap pins turn from inputs into driven outputs.
// RULE_07: After sampling, strap pin 4 carries the first trigger output.
// RULE_08: A strap sampled high selects a test mode, all low selects normal operation.
// RULE_09: The pixel data mask input has software polarity, active high after reset.
// RULE_10: The system holds the test logic reset input low for normal operation.
// RULE_11: The sampled strap values are held until power-on reset is asserted again.
`ifndef RST_STRAP_PARAMS_SVH
`define RST_STRAP_PARAMS_SVH

// Clock and strap sampling delay.
`define CLK_PERIOD_NS      25
`define STRAP_DELAY_NS     1500
`define STRAP_DELAY_CYC    ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_CNT_W        7

// Widths and trigger pin.
`define STRAP_W            8
`define SYNC_W             11
`define TRIG_PIN           4

// Register offsets.
`define REG_CTRL_OFS       8'h00
`define REG_STATUS_OFS     8'h04

// Control register fields and reset value.
`define CTRL_MASK_POL_BIT  0
`define CTRL_TRIG_BIT      1
`define CTRL_RESET         2'h1

// Status register fields.
`define STAT_STATE_LSB     0
`define STAT_DONE_BIT      2
`define STAT_TEST_BIT      3
`define STAT_TLR_BIT       4
`define STAT_STRAP_LSB     8

// AXI responses.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- common/rst_strap_pkg.sv
`default_nettype none
`include "rst_strap_params.svh"

package rst_strap_pkg;

    // Reset release sequence.
    typedef enum logic [1:0] {
        ST_HOLD   = 2'b00,
        ST_SETTLE = 2'b01,
        ST_ACTIVE = 2'b11
    } seq_state_e;

    // Three-stage pin synchroniser state.
    typedef struct packed {
        logic [`SYNC_W-1:0] f1;
        logic [`SYNC_W-1:0] f2;
        logic [`SYNC_W-1:0] f3;
        logic [`SYNC_W-1:0] agreed;
    } sync_s;

endpackage

`default_nettype wire

//--- verilog/pin_sync3.sv
`default_nettype none
`include "rst_strap_params.svh"

module pin_sync3
    import rst_strap_pkg::*;
(
    // Clock and reset.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Asynchronous pins in, settled levels out.
    input  wire logic [`SYNC_W-1:0] pins_in,
    output logic      [`SYNC_W-1:0] pins_out
);

    sync_s r;
    sync_s r_nxt;

    // A bit only moves once the second and third stage agree, so a glitch
    // that lasts one cycle never reaches the sequencer.
    always_comb
    begin
        r_nxt        = r;
        r_nxt.f1     = pins_in;
        r_nxt.f2     = r.f1;
        r_nxt.f3     = r.f2;
        r_nxt.agreed = (r.f2 & r.f3) | (r.agreed & (r.f2 | r.f3));
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= r_nxt;
    end

    assign pins_out = r.agreed;

endmodule

`default_nettype wire

//--- verilog/reset_strap_ctrl.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`default_nettype none
`include "rst_strap_params.svh"

module reset_strap_ctrl
    import rst_strap_pkg::*;
(
    // Clock and reset.
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Device pins.
    input  wire logic                 power_on_reset_n,
    input  wire logic                 test_logic_reset_n,
    input  wire logic                 pixel_data_mask,
    input  wire logic [`STRAP_W-1:0]  test_strap_in,
    output logic      [`STRAP_W-1:0]  test_strap_out,
    output logic      [`STRAP_W-1:0]  test_strap_oe,
    // Status toward the rest of the controller.
    output logic                      config_done,
    output logic                      test_mode,
    output logic                      pixel_mask_active
);

    localparam int DLY_C = `STRAP_DELAY_CYC;

    typedef struct packed {
        seq_state_e           st;
        logic [`STRAP_CNT_W-1:0] cnt;
        logic [`STRAP_W-1:0]  strap;
        logic [`STRAP_W-1:0]  sout;
        logic [`STRAP_W-1:0]  soe;
        logic                 done;
        logic                 tmode;
        logic                 mask_act;
        logic                 mask_pol;
        logic                 trig;
        logic                 aw_have;
        logic [7:0]           aw_addr;
        logic                 w_have;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } ctrl_s;

    ctrl_s r;
    ctrl_s r_nxt;

    logic [`SYNC_W-1:0] pins_s;
    logic               por_s;
    logic               tlr_s;
    logic               mask_s;
    logic [`STRAP_W-1:0] strap_s;
    logic [`STRAP_CNT_W-1:0] settle_cyc;

    // Every pin arrives from outside the clock domain.
    pin_sync3 u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pins_in  ({power_on_reset_n, test_logic_reset_n, pixel_data_mask, test_strap_in}),
        .pins_out (pins_s)
    );

    assign por_s   = pins_s[`SYNC_W-1];
    assign tlr_s   = pins_s[`SYNC_W-2];
    assign mask_s  = pins_s[`SYNC_W-3];
    assign strap_s = pins_s[`STRAP_W-1:0];

    // Status word, shared by the read path.
    function automatic logic [31:0] status_word(input ctrl_s s, input logic tlr);
        logic [31:0] v;
        v = 32'h0;
        v[`STAT_STATE_LSB +: 2]              = s.st;
        v[`STAT_DONE_BIT]                    = s.done;
        v[`STAT_TEST_BIT]                    = s.tmode;
        v[`STAT_TLR_BIT]                     = tlr;
        v[`STAT_STRAP_LSB +: `STRAP_W]       = s.strap;
        return v;
    endfunction

    // Reset release sequence and pin drive. A fall of power-on reset drops
    // everything at once, whatever the sequence was doing.
    always_comb
    begin
        r_nxt = r;
        case (r.st)
            ST_HOLD:
            begin
                r_nxt.cnt = '0;
                if (por_s)
                    r_nxt.st = ST_SETTLE;                       // RULE_01
            end
            ST_SETTLE:
            begin
                if (!por_s)
                    r_nxt.st = ST_HOLD;
                else if (r.cnt == `STRAP_CNT_W'(DLY_C - 1))
                begin
                    r_nxt.st    = ST_ACTIVE;
                    r_nxt.strap = strap_s;                      // RULE_05
                end
                else
                    r_nxt.cnt = r.cnt + `STRAP_CNT_W'(1);
            end
            ST_ACTIVE:
            begin
                if (!por_s)
                    r_nxt.st = ST_HOLD;
            end
            default:
                r_nxt.st = ST_HOLD;
        endcase

        // Outputs follow the next state so that they stand in flip-flops.
        if (r_nxt.st == ST_ACTIVE)
        begin
            r_nxt.soe             = {`STRAP_W{1'b1}};           // RULE_06
            r_nxt.sout            = '0;
            r_nxt.sout[`TRIG_PIN] = r.trig;                     // RULE_07
            r_nxt.done            = 1'b1;
            r_nxt.tmode           = |r_nxt.strap;               // RULE_08
        end
        else
        begin
            r_nxt.soe   = '0;                                   // RULE_04
            r_nxt.sout  = '0;
            r_nxt.done  = 1'b0;                                 // RULE_02
            r_nxt.tmode = 1'b0;
        end
        if (r_nxt.st == ST_HOLD)
            r_nxt.strap = '0;                                   // RULE_11

        // The mask is only honoured once out of power-on reset.
        r_nxt.mask_act = por_s & ~(mask_s ^ r.mask_pol);        // RULE_09

        // Write path: address and data are taken in either order.
        if (s_axi_awvalid && r.awready)
        begin
            r_nxt.aw_have = 1'b1;
            r_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready)
        begin
            r_nxt.w_have = 1'b1;
            r_nxt.w_data = s_axi_wdata;
            r_nxt.w_strb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready)
            r_nxt.bvalid = 1'b0;
        if (r.aw_have && r.w_have && !r.bvalid)
        begin
            r_nxt.aw_have = 1'b0;
            r_nxt.w_have  = 1'b0;
            r_nxt.bvalid  = 1'b1;
            r_nxt.bresp   = `RESP_OKAY;
            if (r.aw_addr[7:2] == `REG_CTRL_OFS >> 2)
            begin
                if (r.w_strb[0])
                begin
                    r_nxt.mask_pol = r.w_data[`CTRL_MASK_POL_BIT];
                    r_nxt.trig     = r.w_data[`CTRL_TRIG_BIT];
                end
            end
            else if (r.aw_addr[7:2] != `REG_STATUS_OFS >> 2)
                r_nxt.bresp = `RESP_SLVERR;
        end
        r_nxt.awready = !r_nxt.aw_have && !r_nxt.bvalid;
        r_nxt.wready  = !r_nxt.w_have && !r_nxt.bvalid;

        // Read path: one read at a time, answered the cycle after it is taken.
        if (r.rvalid && s_axi_rready)
            r_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && r.arready)
        begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp  = `RESP_OKAY;
            if (s_axi_araddr[7:2] == `REG_CTRL_OFS >> 2)
                r_nxt.rdata = {30'h0, r.trig, r.mask_pol};
            else if (s_axi_araddr[7:2] == `REG_STATUS_OFS >> 2)
                r_nxt.rdata = status_word(r, tlr_s);
            else
            begin
                r_nxt.rdata = 32'h0;
                r_nxt.rresp = `RESP_SLVERR;
            end
        end
        r_nxt.arready = !r_nxt.rvalid;
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r          <= '0;
            r.st       <= ST_HOLD;
            r.mask_pol <= 1'(`CTRL_RESET >> `CTRL_MASK_POL_BIT);
        end
        else
            r <= r_nxt;
    end

    // Ports come straight from the state register.
    assign s_axi_awready     = r.awready;
    assign s_axi_wready      = r.wready;
    assign s_axi_bvalid      = r.bvalid;
    assign s_axi_bresp       = r.bresp;
    assign s_axi_arready     = r.arready;
    assign s_axi_rvalid      = r.rvalid;
    assign s_axi_rdata       = r.rdata;
    assign s_axi_rresp       = r.rresp;
    assign test_strap_out    = r.sout;
    assign test_strap_oe     = r.soe;
    assign config_done       = r.done;
    assign test_mode         = r.tmode;
    assign pixel_mask_active = r.mask_act;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // The sequence leaves hold only on a released reset.
    property p_start_on_rise;
        (r.st == ST_HOLD) |=> (r.st == ST_SETTLE) == $past(por_s);
    endproperty
    a_start_on_rise: assert property (p_start_on_rise) // RULE_01
        else $error("sequence did not follow reset release");

    // With reset held low, nothing is driven or flagged.
    property p_inactive_in_reset;
        (!por_s && !$past(por_s)) |-> (test_strap_oe == '0 && !config_done
            && !test_mode && !pixel_mask_active && test_strap_out == '0);
    endproperty
    a_inactive_in_reset: assert property (p_inactive_in_reset) // RULE_02
        else $error("output active during power-on reset");

    // Straps float until the sample is taken.
    property p_float_before_sample;
        (r.st != ST_ACTIVE) |-> (test_strap_oe == '0);
    endproperty
    a_float_before_sample: assert property (p_float_before_sample) // RULE_04
        else $error("strap pin driven before sampling");

    // Cycles spent in settle, counted apart from the sequencer so that the
    // delay check does not lean on the counter it is meant to judge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || r.st != ST_SETTLE)
            settle_cyc <= '0;
        else
            settle_cyc <= settle_cyc + `STRAP_CNT_W'(1);
    end

    // The sample falls exactly the set delay after settling starts.
    property p_sample_delay;
        (r.st == ST_ACTIVE && $past(r.st) == ST_SETTLE)
            |-> settle_cyc == `STRAP_CNT_W'(DLY_C);
    endproperty
    a_sample_delay: assert property (p_sample_delay) // RULE_05
        else $error("strap sample not at the set delay");

    // Entering active keeps what the pins showed at that edge.
    property p_sample_value;
        $rose(r.st == ST_ACTIVE) |-> r.strap == $past(strap_s);
    endproperty
    a_sample_value: assert property (p_sample_value) // RULE_05
        else $error("latched strap differs from pins");

    // After sampling every strap pin is driven.
    property p_drive_after;
        (r.st == ST_ACTIVE) |-> (test_strap_oe == {`STRAP_W{1'b1}}) && config_done;
    endproperty
    a_drive_after: assert property (p_drive_after) // RULE_06
        else $error("strap pins not driven after sampling");

    // Pin 4 follows the trigger control one cycle behind.
    property p_trigger;
        (r.st == ST_ACTIVE && $past(r.st) == ST_ACTIVE)
            |-> test_strap_out[`TRIG_PIN] == $past(r.trig);
    endproperty
    a_trigger: assert property (p_trigger) // RULE_07
        else $error("trigger output not on strap pin 4");

    // Test mode is any high strap once active.
    property p_test_mode;
        test_mode == ((r.st == ST_ACTIVE) && (|r.strap));
    endproperty
    a_test_mode: assert property (p_test_mode) // RULE_08
        else $error("test mode does not match straps");

    // Mask polarity follows the control bit.
    property p_mask_pol;
        $past(por_s) |-> pixel_mask_active == ~($past(mask_s) ^ $past(r.mask_pol));
    endproperty
    a_mask_pol: assert property (p_mask_pol) // RULE_09
        else $error("pixel mask polarity wrong");

    // Latched straps do not move while active.
    property p_strap_hold;
        (r.st == ST_ACTIVE && $past(r.st) == ST_ACTIVE) |-> $stable(r.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold) // RULE_11
        else $error("latched strap changed while active");

endmodule

`default_nettype wire

//--- test/por_companion.sv
`default_nettype none

module por_companion (
    // Clock.
    input  wire logic       aclk,
    // Bench controls: release request, supply settle time, external pullups.
    input  wire logic       release_req,
    input  wire logic [7:0] stable_cyc,
    input  wire logic [7:0] pull_lvl,
    // Strap pins as the controller drives them.
    input  wire logic [7:0] strap_out,
    input  wire logic [7:0] strap_oe,
    // Pins toward the controller.
    output logic            power_on_reset_n,
    output logic            test_logic_reset_n,
    output logic [7:0]      strap_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] settle_r;

    // Reset is let go only once supplies have settled for the requested time.
    always_ff @(posedge aclk)
    begin
        if (!release_req)
        begin
            settle_r         <= 8'h00;
            power_on_reset_n <= 1'b0;
        end
        else if (settle_r < stable_cyc)
            settle_r <= settle_r + 8'h01;
        else
            power_on_reset_n <= 1'b1;
    end

    // The test logic reset pin is strapped low for normal operation.
    assign test_logic_reset_n = 1'b0;

    // An undriven strap falls to its pull level, never to a remembered value.
    assign strap_wire = (strap_oe & strap_out) | (~strap_oe & pull_lvl);
endmodule

`default_nettype wire

//--- test/reset_and_test_strap_sampling_tb_top.sv
`default_nettype none
`include "rst_strap_params.svh"

module reset_and_test_strap_sampling_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk = 0, aresetn = 0, rel = 0, pdm = 0;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00, pu = 8'h00, sout, soe, swire;
    logic [31:0] wd = 32'h0, rd;
    logic [3:0] ws = 4'hF;
    logic awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
    logic [1:0] bresp, rresp, resp;
    logic por_n, tlr_n, done, tmode, mact;
    int err_total = 0, compares = 0, n;

    always #12.5 aclk = ~aclk;

    por_companion comp (.aclk(aclk), .release_req(rel), .stable_cyc(8'h05), .pull_lvl(pu),
        .strap_out(sout), .strap_oe(soe), .power_on_reset_n(por_n),
        .test_logic_reset_n(tlr_n), .strap_wire(swire));

    reset_strap_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .power_on_reset_n(por_n), .test_logic_reset_n(tlr_n), .pixel_data_mask(pdm),
        .test_strap_in(swire), .test_strap_out(sout), .test_strap_oe(soe),
        .config_done(done), .test_mode(tmode), .pixel_mask_active(mact));

    // Verdict and end of run.
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // A wait that runs out is a mismatch and ends the run.
    task automatic timed_out(input string what);
        err_total++;
        $display("ERROR %0t timeout: %s", $time, what);
        wrap_up();
    endtask

    // Both write channels offered together; each dropped once it is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        aw_a <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
            if (bv && br)
                break;
        end
        if (n >= 100)
            timed_out("write");
        r = bresp;
        br <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ar_a <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (arv && arr)
                arv <= 1'b0;
            if (rv && rr)
                break;
        end
        if (n >= 100)
            timed_out("read");
        d = rd;
        r = rresp;
        rr <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp, what);
        chk({30'h0, r}, {30'h0, `RESP_OKAY}, "read response");
    endtask

    // Hold reset for a while: nothing active, straps floating, no sequence started.
    task automatic t_hold();
        rel <= 1'b0;
        pdm <= 1'b1;
        repeat (20)
        begin
            @(posedge aclk);
            chk({done, tmode, mact, soe, sout}, 19'h0, "outputs while held");
            chk(soe, 8'h00, "strap drive while held");
        end
        rd_chk(`REG_STATUS_OFS, 32'h0, "status while held");
    endtask

    // Release and time the strap sample from the reset pin edge.
    task automatic t_release(input logic [7:0] straps, input logic [31:0] stat);
        pu <= straps;
        rel <= 1'b1;
        for (n = 0; n < 50 && por_n !== 1'b1; n++)
            @(posedge aclk);
        if (por_n !== 1'b1)
            timed_out("reset release");
        // Done is looked at before each edge, so the edge that raises it
        // together with the strap drive is not counted against it.
        for (n = 0; n < 200 && soe !== 8'hFF; n++)
        begin
            chk(done, 1'b0, "done before sample");
            @(posedge aclk);
        end
        chk(n >= 62 && n <= 67, 1'b1, "strap sample delay");
        chk(soe, 8'hFF, "straps driven");
        chk(tmode, |straps, "test mode select");
        pu <= 8'h00;
        repeat (5) @(posedge aclk);
        rd_chk(`REG_STATUS_OFS, stat, "status after sample");
    endtask

    // Trigger output level follows the control bit on strap 4 only.
    task automatic t_trigger();
        axi_wr(`REG_CTRL_OFS, 32'h3, resp);
        chk(sout, 8'h10, "trigger high");
        axi_wr(`REG_CTRL_OFS, 32'h1, resp);
        chk(sout, 8'h00, "trigger low");
    endtask

    // Mask polarity: default active high, then inverted by software.
    task automatic t_mask();
        rd_chk(`REG_CTRL_OFS, 32'h1, "control reset value");
        chk(mact, 1'b1, "mask high active");
        axi_wr(`REG_CTRL_OFS, 32'h0, resp);
        repeat (2) @(posedge aclk);
        chk(mact, 1'b0, "mask high inverted");
        pdm <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(mact, 1'b1, "mask low inverted");
        axi_wr(`REG_CTRL_OFS, 32'h1, resp);
    endtask

    // Unmapped address refused on both paths; a write without its low byte
    // lane leaves control alone; status is read only.
    task automatic t_bus_errors();
        logic [31:0] d;
        axi_wr(8'h10, 32'h3, resp);
        chk(resp, `RESP_SLVERR, "unmapped write");
        axi_rd(8'h10, d, resp);
        chk(d, 32'h0, "unmapped read data");
        chk(resp, `RESP_SLVERR, "unmapped read");
        ws <= 4'h0;
        axi_wr(`REG_CTRL_OFS, 32'h2, resp);
        ws <= 4'hF;
        chk(resp, `RESP_OKAY, "lane masked write response");
        rd_chk(`REG_CTRL_OFS, 32'h1, "control after refused writes");
        axi_wr(`REG_STATUS_OFS, 32'hFFFF, resp);
        chk(resp, `RESP_OKAY, "status write response");
        rd_chk(`REG_STATUS_OFS, 32'h0000A50F, "status after write");
    endtask

    // Reset pin dropped mid-settle: no sample, straps stay floating.
    task automatic t_abort();
        rel <= 1'b0;
        repeat (10) @(posedge aclk);
        chk({tmode, soe}, 9'h0, "cleared on reset");
        pu <= 8'hFF;
        rel <= 1'b1;
        repeat (35) @(posedge aclk);
        rel <= 1'b0;
        repeat (80)
        begin
            @(posedge aclk);
            chk(soe, 8'h00, "no sample after abort");
        end
    endtask

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_hold();
        t_release(8'h00, 32'h00000007);
        t_trigger();
        t_mask();
        t_abort();
        t_hold();
        t_release(8'hA5, 32'h0000A50F);
        t_bus_errors();
        wrap_up();
    end
endmodule

`default_nettype wire
